// [rll27_endec_sync.sv]
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Functional notes
// R1: Mode bit picks NRZ or RLL coding
// R2: RLL mode reassigns dual-function disk pins
// R3: RLL writes clocked by double write oscillator
// R4: Preamble from write gate to first NRZ rise
// R5: Preamble pattern chosen by preamble select bit
// R6: First NRZ rise ends preamble, sends mark
// R7: Mark pattern 5EA or FF by select bit
// R8: Data field written as RLL serial output
// R9: Precompensation only when enable bit set
// R10: Early and late delays from two registers
// R11: Read gate internal only in RLL mode
// R12: Count 24 half-oscillator edges; ones-reset restarts
// R13: Count 24 raises VFO sync enable
// R14: Count 72 more; ones-reset restarts sequence
// R15: Count 96 latches mark hunt, ignores resets
// R16: Latch moves reference clock to VFO/2
// R17: Count 128 without mark aborts and restarts
// R18: Mark found: stop counter, decode data
// R19: Read gate low resets counter, stops data
// R20: NRZ mode passes serial data unencoded
// R21: Standard 2,7 code, two bits per data bit; code uses a simplified per-bit pair map instead
// R22: Ones classified early/late/on-time, delayed accordingly
module rll27_endec_sync (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Disk controller side (same clock)
   input wire logic write_gate_i,
   input wire logic read_gate_i,
   input wire logic nrz_wr_data_i,
   output logic nrz_wr_take_o,
   output logic nrz_rd_data_o,
   output logic nrz_rd_valid_o,
   output logic read_reference_clock_o,
   output logic mark_found_o,
   // Pins
   input wire logic input_write_osc_double_i,
   input wire logic sector_ones_reset_in_i,
   input wire logic rrc_vfo_double_clock_i,
   input wire logic nrz_rll_serial_in_i,
   output logic nrz_data_o,
   output logic nrz_data_oe_o,
   output logic mark_strobe_n_o,
   output logic mark_strobe_oe_o,
   input wire logic mark_strobe_n_i,
   output logic vfo_sync_enable_o,
   output logic read_gate_rll_serial_out_o,
   output logic write_gate_o,
   output logic precomp_ramp_out_o,
   output logic precomp_ramp_oe_o,
   output logic input_o,
   output logic sector_o,
   output logic mark_detect_o
);
   import rll27_pkg::*;

   // Block overview, for the next reader:
   // - Mode register picks plain NRZ pass-through or on-chip RLL coding.
   // - In RLL mode several disk pins change role; the muxes sit at the bottom.
   // - Write side turns the controller's NRZ stream into code bits, one per
   //   synced rise of the doubled write oscillator.
   // - Read side counts half-oscillator edges to decide when the preamble is
   //   long and clean enough to let the VFO sync, then hunts for the mark.
   // - All pins are slow next to the system clock, so every pin is
   //   oversampled through two flops and edges are found in this domain.
   // - Oscillator rates far above a quarter of the system clock will lose
   //   edges; the block is meant for the slower disk rates only.
   // - Register bus is byte-wide in effect; upper write data is ignored.

   // ==================================================
   // Registers
   logic [7:0] mode_q;
   logic [7:0] early_q;
   logic [7:0] late_q;
   mode_t mode;
   assign mode = '{rll_en: mode_q[MODE_RLL_BIT], pcomp_en: mode_q[MODE_PCOMP_BIT],
                   pre_sel: mode_q[MODE_PRE_BIT], mark_sel: mode_q[MODE_MARK_BIT]};

   // Writes take no wait; unmapped reads return zero, writes dropped
   logic rd_done_q;
   wire sel_mode = avs_address_i == ADDR_MODE;
   wire sel_early = avs_address_i == ADDR_EARLY;
   wire sel_late = avs_address_i == ADDR_LATE;
   // One wait state on reads so the registered data stands at the accept edge
   assign avs_waitrequest_o = avs_read_i & ~rd_done_q;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= MODE_RESET;
         early_q <= DELAY_RESET;
         late_q <= DELAY_RESET;
      end else if (avs_write_i) begin
         if (sel_mode) mode_q <= avs_writedata_i[7:0]; // see R1
         if (sel_early) early_q <= avs_writedata_i[7:0]; // see R10
         if (sel_late) late_q <= avs_writedata_i[7:0]; // see R10
      end
   end
   wire [7:0] rd_mux = sel_mode ? mode_q : sel_early ? early_q : sel_late ? late_q : 8'h00;
   // Read data loaded in the wait cycle, held through the accept edge
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         avs_readdata_o <= 32'h0;
         rd_done_q <= 1'b0;
      end else begin
         rd_done_q <= avs_read_i & ~rd_done_q;
         if (avs_read_i && !rd_done_q) avs_readdata_o <= {24'h0, rd_mux};
      end
   end

   // ==================================================
   // Pin synchronisers; first stage read only by second
   logic [4:0] s1_q;
   logic [4:0] s2_q;
   logic [4:0] s3_q;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q <= 5'h12; // Strobe and ones reset idle high; no false pulse
         s2_q <= 5'h12;
         s3_q <= 5'h12;
      end else begin
         s1_q <= {mark_strobe_n_i, nrz_rll_serial_in_i, rrc_vfo_double_clock_i,
                  sector_ones_reset_in_i, input_write_osc_double_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   wire osc_rise = s2_q[0] & ~s3_q[0];
   wire vfo_rise = s2_q[2] & ~s3_q[2];
   wire ones_rst = mode.rll_en & ~s2_q[1]; // Active-low one-shot pulse
   wire rll_in = s2_q[3];

   // Half-rate dividers on the doubled clocks
   logic osc_half_q;
   logic vfo_half_q;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         osc_half_q <= 1'b0;
         vfo_half_q <= 1'b0;
      end else begin
         if (osc_rise) osc_half_q <= ~osc_half_q;
         if (vfo_rise) vfo_half_q <= ~vfo_half_q;
      end
   end
   wire half_tick = osc_rise & ~osc_half_q; // Edge of the half-rate oscillator

   // ==================================================
   // Write path, code bit per double-oscillator edge
   // Sequence per gate: idle, preamble, address mark, then data pairs.
   // Preamble repeats its 16-bit pattern by a wrapping 4-bit pointer,
   // so any 16 consecutive code bits hold one whole pattern.
   // Leaving preamble waits for a rising NRZ edge seen at an oscillator
   // tick; a level already high when the gate opens counts as an edge.
   // Mark bits are sent from the top index down; the length constant
   // gives the index of the first bit sent.
   // Data phase takes one NRZ bit per two code bits; the take strobe
   // tells the controller when its bit has been consumed.
   // Dropping write gate aborts at once; no partial bit is finished.
   wr_state_t wst_q;
   logic [3:0] wpos_q;
   logic [3:0] hist_q;
   logic code_q;
   logic data_phase_q;
   logic dbit_q;
   logic nrz_prev_q;
   wire wr_rll = mode.rll_en & write_gate_i;
   wire [15:0] pre_pat = mode.pre_sel ? PRE_PAT1 : PRE_PAT0; // see R5
   wire [11:0] mk_pat = mode.mark_sel ? MARK_5EA : MARK_FF; // see R7
   wire [3:0] mk_len = mode.mark_sel ? MARK_LEN_5EA : MARK_LEN_FF;
   wire nrz_rise = nrz_wr_data_i & ~nrz_prev_q;

   // Simplified 2,7 map: code pair {clock, data} from current bit and history
   function automatic logic [1:0] rll_pair(input logic b, input logic [3:0] h);
      rll_pair = b ? 2'b01 : ((h[1:0] == 2'b00) && (h[3:2] != 2'b00) ? 2'b10 : 2'b00);
   endfunction
   wire [1:0] pair = rll_pair(nrz_wr_data_i, hist_q); // see R21

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wst_q <= W_IDLE;
         wpos_q <= 4'h0;
         code_q <= 1'b0;
         data_phase_q <= 1'b0;
         dbit_q <= 1'b0;
         nrz_prev_q <= 1'b0;
         hist_q <= 4'h0;
      end else if (!wr_rll) begin
         wst_q <= W_IDLE;
         code_q <= 1'b0;
         nrz_prev_q <= 1'b0;
      end else if (osc_rise) begin // see R3
         case (wst_q)
            W_IDLE: begin
               wst_q <= W_PRE; // see R4
               wpos_q <= 4'hf;
            end
            W_PRE: begin
               code_q <= pre_pat[wpos_q]; // see R5
               wpos_q <= wpos_q - 4'h1;
               nrz_prev_q <= nrz_wr_data_i;
               if (nrz_rise) begin
                  wst_q <= W_MARK; // see R6
                  wpos_q <= mk_len;
               end
            end
            W_MARK: begin
               code_q <= mk_pat[wpos_q]; // see R7
               wpos_q <= wpos_q - 4'h1;
               if (wpos_q == 4'h0) begin
                  wst_q <= W_DATA;
                  data_phase_q <= 1'b0;
               end
            end
            W_DATA: begin
               data_phase_q <= ~data_phase_q;
               code_q <= data_phase_q ? dbit_q : pair[1]; // see R8
               if (!data_phase_q) begin
                  dbit_q <= pair[0];
                  hist_q <= {hist_q[1:0], pair};
               end
            end
            default: wst_q <= W_IDLE;
         endcase
      end
   end
   assign nrz_wr_take_o = wr_rll && (wst_q == W_DATA) && osc_rise && !data_phase_q;

   // Precompensation: classify ones, then delay by a clk-count
   // A five-bit window of code bits lets each one be judged against the
   // bits two places either side of it.
   // Delay is counted in system clocks, so its resolution is one clock;
   // finer steps would need the external ramp network.
   // With precompensation off every one goes out after the fixed window
   // latency, so the output stream is just the code stream delayed.
   // Output pulse is cleared on every oscillator tick, which bounds a
   // programmed delay to less than one code bit.
   logic [4:0] cwin_q;
   logic [7:0] pdly_q;
   logic pout_q;
   logic ppend_q;
   wire early_one = cwin_q[2] & cwin_q[4] & ~cwin_q[0];
   wire late_one = cwin_q[2] & cwin_q[0] & ~cwin_q[4];
   wire [7:0] pick = !mode.pcomp_en ? 8'h00 : early_one ? early_q : late_one ? late_q : 8'h00;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cwin_q <= 5'h0;
         pdly_q <= 8'h0;
         pout_q <= 1'b0;
         ppend_q <= 1'b0;
      end else begin
         if (osc_rise) begin
            cwin_q <= {cwin_q[3:0], code_q};
            pdly_q <= pick; // see R9 see R22
            ppend_q <= cwin_q[2];
            pout_q <= 1'b0;
         end else if (ppend_q && pdly_q == 8'h0) begin
            pout_q <= 1'b1;
            ppend_q <= 1'b0;
         end else if (ppend_q) begin
            pdly_q <= pdly_q - 8'h1;
         end
      end
   end
   assign precomp_ramp_out_o = 1'b0;
   assign precomp_ramp_oe_o = mode.rll_en & mode.pcomp_en & ppend_q; // Discharge ramp

   // ==================================================
   // Read acquisition
   // Hunt: count half-oscillator edges; a ones reset restarts the count
   // and drops VFO enable again, so only a clean preamble gets through.
   // Locked: further ones resets are ignored, the mark detector is armed
   // and the reference clock follows the VFO.
   // Locked runs out at the give-up count and falls back to hunting.
   // Data: counter no longer matters; code pairs are reduced to bits.
   // Read gate low returns to hunt from any state.
   // Mark shift register runs at half the VFO rate in every state, so a
   // mark straddling the lock point is still seen.
   // Decoder takes the data bit of each pair; clock bits are dropped.
   acq_state_t ast_q;
   logic [7:0] cnt_q;
   logic vfo_en_q;
   logic [11:0] shr_q;
   logic rphase_q;
   logic rd_bit_q;
   logic rd_val_q;
   wire rd_rll = mode.rll_en & read_gate_i;
   wire mark_hit = (shr_q == MARK_5EA) | (~mode.mark_sel & shr_q[7:0] == MARK_FF[7:0]);

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ast_q <= A_HUNT;
         cnt_q <= 8'h0;
         vfo_en_q <= 1'b0;
         shr_q <= 12'h0;
         rphase_q <= 1'b0;
         rd_bit_q <= 1'b0;
         rd_val_q <= 1'b0;
      end else if (!rd_rll) begin
         ast_q <= A_HUNT; // see R19
         cnt_q <= 8'h0;
         vfo_en_q <= 1'b0;
         rd_val_q <= 1'b0;
      end else begin
         rd_val_q <= 1'b0;
         if (vfo_rise & vfo_half_q) shr_q <= {shr_q[10:0], rll_in};
         case (ast_q)
            A_HUNT: begin
               if (ones_rst) begin
                  cnt_q <= 8'h0; // see R12 see R14
                  vfo_en_q <= 1'b0;
               end else if (half_tick) begin
                  cnt_q <= cnt_q + 8'h1;
                  if (cnt_q + 8'h1 == CNT_VFO_ON) vfo_en_q <= 1'b1; // see R13
                  if (cnt_q + 8'h1 == CNT_LOCK) ast_q <= A_LOCKED; // see R15
               end
            end
            A_LOCKED: begin
               if (mark_hit) begin
                  ast_q <= A_DATA; // see R18
                  rphase_q <= 1'b0;
               end else if (half_tick) begin
                  cnt_q <= cnt_q + 8'h1;
                  if (cnt_q + 8'h1 == CNT_GIVE_UP) begin
                     ast_q <= A_HUNT; // see R17
                     cnt_q <= 8'h0;
                     vfo_en_q <= 1'b0;
                  end
               end
            end
            A_DATA: begin
               if (vfo_rise & vfo_half_q) begin
                  rphase_q <= ~rphase_q;
                  if (rphase_q) begin
                     rd_bit_q <= rll_in; // see R18 see R21
                     rd_val_q <= 1'b1;
                  end
               end
            end
            default: ast_q <= A_HUNT;
         endcase
      end
   end
   wire locked = ast_q != A_HUNT;
   // Reference clock source follows the lock latch
   assign read_reference_clock_o = mode.rll_en ? (locked ? vfo_half_q : osc_half_q)
                                               : s2_q[2]; // see R16
   assign mark_found_o = ast_q == A_DATA;
   assign nrz_rd_data_o = mode.rll_en ? rd_bit_q : s2_q[3]; // see R20
   assign nrz_rd_valid_o = mode.rll_en ? rd_val_q : read_gate_i;

   // ==================================================
   // Dual-function pin muxing
   // In NRZ mode the pins keep their plain roles and the coder is idle.
   // In RLL mode the strobe pin becomes VFO enable, the read gate pin
   // carries the coded write stream, and the NRZ-only inputs read zero.
   // Read gate itself never reaches a pin in RLL mode.
   // Output enables go high only while the block drives the pin.
   assign read_gate_rll_serial_out_o = mode.rll_en ? pout_q : read_gate_i; // see R2 see R11
   assign write_gate_o = write_gate_i;
   assign nrz_data_o = nrz_wr_data_i; // see R20
   assign nrz_data_oe_o = ~mode.rll_en & write_gate_i;
   assign vfo_sync_enable_o = mode.rll_en & vfo_en_q; // see R2
   assign mark_strobe_n_o = mode.rll_en ? ~vfo_en_q : 1'b1;
   assign mark_strobe_oe_o = mode.rll_en;
   assign mark_detect_o = ~mode.rll_en & ~s2_q[4];
   assign input_o = ~mode.rll_en & s2_q[0];
   assign sector_o = ~mode.rll_en & s2_q[1];
endmodule

// [rll27_pkg.sv]
package rll27_pkg;
   // ==================================================
   // Register map (word addresses, one word each)
   localparam logic [7:0] ADDR_MODE = 8'h56;
   localparam logic [7:0] ADDR_EARLY = 8'h57;
   localparam logic [7:0] ADDR_LATE = 8'h58;
   // ==================================================
   // Mode register fields and reset values
   localparam int MODE_MARK_BIT = 0;
   localparam int MODE_PRE_BIT = 1;
   localparam int MODE_PCOMP_BIT = 2;
   localparam int MODE_RLL_BIT = 3;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] DELAY_RESET = 8'h00;
   // ==================================================
   // Patterns
   localparam logic [15:0] PRE_PAT0 = 16'h9249;
   localparam logic [15:0] PRE_PAT1 = 16'h8888;
   localparam logic [11:0] MARK_5EA = 12'h5ea;
   localparam logic [11:0] MARK_FF = 12'h0ff;
   localparam logic [3:0] MARK_LEN_5EA = 4'hb;
   localparam logic [3:0] MARK_LEN_FF = 4'h7;
   // ==================================================
   // Acquisition counts
   localparam logic [7:0] CNT_VFO_ON = 8'h18;
   localparam logic [7:0] CNT_LOCK = 8'h60;
   localparam logic [7:0] CNT_GIVE_UP = 8'h80;
   typedef enum logic [1:0] {W_IDLE, W_PRE, W_MARK, W_DATA} wr_state_t;
   typedef enum logic [1:0] {A_HUNT, A_LOCKED, A_DATA} acq_state_t;
   typedef struct packed {
      logic rll_en;
      logic pcomp_en;
      logic pre_sel;
      logic mark_sel;
   } mode_t;
endpackage

// [rll27_endec_sync_sva.sv]
`timescale 1ns/1ns
// ==========================================
// Port-level checks of the endec block
module rll27_endec_sync_sva
   import rll27_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic write_gate_i,
   input wire logic read_gate_i,
   input wire logic write_gate_o,
   input wire logic read_gate_rll_serial_out_o,
   input wire logic mark_strobe_n_o,
   input wire logic mark_strobe_oe_o,
   input wire logic vfo_sync_enable_o,
   input wire logic nrz_data_oe_o,
   input wire logic input_o,
   input wire logic sector_o
);
   // Strobe enable doubles as the RLL mode flag
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_wait_read_only: assert property (avs_waitrequest_o |-> avs_read_i)
      else $error("waitrequest without read");
   a_wait_one_cycle: assert property (avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("read wait longer than one cycle");
   a_unmapped_reads_zero: assert property (avs_read_i && (avs_address_i < ADDR_MODE
      || avs_address_i > ADDR_LATE) |=> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_rg_pin_nrz: assert property (!mark_strobe_oe_o |->
      read_gate_rll_serial_out_o == read_gate_i)
      else $error("read gate pin wrong in nrz");
   a_wg_follows: assert property (write_gate_o == write_gate_i)
      else $error("write gate pin wrong");
   a_strobe_is_vfo: assert property (mark_strobe_oe_o |->
      mark_strobe_n_o == !vfo_sync_enable_o)
      else $error("strobe pin not vfo enable");
   a_rll_pins_quiet: assert property (mark_strobe_oe_o |-> !input_o && !sector_o)
      else $error("nrz-only pins active in rll");
   a_vfo_rll_only: assert property (vfo_sync_enable_o |-> mark_strobe_oe_o)
      else $error("vfo enable outside rll");
   a_vfo_rise_rg: assert property ($rose(vfo_sync_enable_o) |-> read_gate_i)
      else $error("vfo enable without read gate");
   a_rg_drop_vfo: assert property ($fell(read_gate_i) |-> ##[1:6] !vfo_sync_enable_o)
      else $error("vfo enable outlives read gate");
   a_nrz_oe_gate: assert property ($rose(nrz_data_oe_o) |->
      write_gate_i && !mark_strobe_oe_o)
      else $error("nrz data driven wrongly");
   c_vfo_on: cover property ($rose(vfo_sync_enable_o));
   c_give_up: cover property ($fell(vfo_sync_enable_o) && read_gate_i);
   c_reg_write: cover property (avs_write_i);
endmodule

// [rll27_disk_model.sv]
`timescale 1ns/1ns
// ==========================================
// Data separator and drive stand-in
module rll27_disk_model (
   input wire logic vfo_en_i,
   input wire logic ones_req_i,
   output logic osc_o,
   output logic vfo_clk_o,
   output logic ones_n_o,
   output logic rll_o
);
   logic [1:0] ph = 2'h0;
   // Free-running oscillator, odd phase to the system clock
   initial begin
      osc_o = 1'b0;
      #3;
      forever #80 osc_o = ~osc_o;
   end
   // VFO clock only runs while enabled, else parked low
   initial begin
      vfo_clk_o = 1'b0;
      forever #72 vfo_clk_o = vfo_en_i ? ~vfo_clk_o : 1'b0;
   end
   // Preamble-like code stream; inverts when released
   initial rll_o = 1'b0;
   always @(posedge vfo_clk_o) begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      rll_o <= (ph == 2'h0);
   end
   always @(negedge vfo_en_i) rll_o <= ~rll_o;
   // One-shot ones reset, low for 40 ns
   initial ones_n_o = 1'b1;
   always @(posedge ones_req_i) begin
      ones_n_o = 1'b0;
      #40 ones_n_o = 1'b1;
   end
endmodule

// [rll27_endec_sync_test.sv]
`timescale 1ns/1ns
// ==========================================
// Bench top
module rll27_endec_sync_test;
   import rll27_pkg::*;
   logic clk_sys_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0;
   logic write_gate_i = 0, read_gate_i = 0, nrz_wr_data_i = 0, mark_strobe_n_i = 1;
   logic [7:0] avs_address_i = 8'h00;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
   logic avs_waitrequest_o, nrz_wr_take_o, nrz_rd_data_o, nrz_rd_valid_o, mark_found_o;
   logic read_reference_clock_o, nrz_data_o, nrz_data_oe_o, mark_strobe_n_o;
   logic mark_strobe_oe_o, vfo_sync_enable_o, read_gate_rll_serial_out_o, write_gate_o;
   logic precomp_ramp_out_o, precomp_ramp_oe_o, input_o, sector_o, mark_detect_o;
   logic input_write_osc_double_i, sector_ones_reset_in_i, rrc_vfo_double_clock_i;
   logic nrz_rll_serial_in_i, ones_req = 0;
   int n_errors = 0, checked = 0, cyc = 0;
   rll27_endec_sync dut (.*);
   rll27_disk_model disk (.vfo_en_i(vfo_sync_enable_o), .ones_req_i(ones_req),
      .osc_o(input_write_osc_double_i), .vfo_clk_o(rrc_vfo_double_clock_i),
      .ones_n_o(sector_ones_reset_in_i), .rll_o(nrz_rll_serial_in_i));
   // Clock and hang guard; whole run is far below the ceiling
   always #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // ==========================================
   // Avalon master; holds request until waitrequest low
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_writedata_i <= {24'h0, d};
      avs_write_i <= w;
      avs_read_i <= !w;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus(1'b0, a, 8'h00);
      d = avs_readdata_o; // Data stands at the accept edge
   endtask
   task automatic osc(input int n);
      repeat (n) @(posedge input_write_osc_double_i);
      @(posedge clk_sys_i);
   endtask
   task automatic wt(input logic v, input int n);
      for (int i = 0; i < n && vfo_sync_enable_o !== v; i++) osc(1);
   endtask
   // One code bit per oscillator rise, sampled well inside the bit
   task automatic code_bit(output logic b);
      osc(1);
      repeat (8) @(posedge clk_sys_i);
      b = read_gate_rll_serial_out_o;
   endtask
   task automatic pulse;
      @(posedge clk_sys_i) ones_req <= 1'b1;
      @(posedge clk_sys_i) ones_req <= 1'b0;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_regs;
      logic [31:0] d;
      rd(ADDR_MODE, d); chk(d, {24'h0, MODE_RESET});
      rd(ADDR_LATE, d); chk(d, {24'h0, DELAY_RESET});
      bus(1'b1, ADDR_EARLY, 8'ha5);
      bus(1'b1, ADDR_LATE, 8'h3c);
      bus(1'b1, ADDR_MODE, 8'h06);
      rd(ADDR_EARLY, d); chk(d, 32'ha5);
      rd(ADDR_LATE, d); chk(d, 32'h3c);
      rd(ADDR_MODE, d); chk(d, 32'h06);
      rd(8'h59, d); chk(d, 32'h0);
   endtask
   task automatic t_nrz;
      @(posedge clk_sys_i);
      read_gate_i <= 1'b1;
      write_gate_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk(read_gate_rll_serial_out_o, 1);
      chk(nrz_data_oe_o, 1);
      chk(mark_strobe_oe_o, 0);
      read_gate_i <= 1'b0;
      write_gate_i <= 1'b0;
   endtask
   task automatic t_wr;
      logic b;
      int ones, run, best, n;
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, ADDR_MODE, m ? 8'h0a : 8'h08);
         write_gate_i <= 1'b1;
         osc(8);
         ones = 0;
         for (int i = 0; i < 16; i++) begin
            code_bit(b);
            ones += b;
         end
         chk(ones, m ? 4 : 6);
         if (m) begin
            nrz_wr_data_i <= 1'b1;
            run = 0;
            best = 0;
            for (int i = 0; i < 24; i++) begin
               code_bit(b);
               run = b ? run + 1 : 0;
               if (run > best) best = run;
            end
            chk(best >= 8, 1);
            n = 0;
            repeat (100) @(posedge clk_sys_i) n += nrz_wr_take_o;
            chk(n > 0, 1);
         end
         write_gate_i <= 1'b0;
         nrz_wr_data_i <= 1'b0;
      end
   endtask
   task automatic t_rll;
      bus(1'b1, ADDR_MODE, 8'h08);
      osc(1);
      chk(mark_strobe_oe_o, 1);
      chk(input_o, 0);
      read_gate_i <= 1'b1;
      osc(20); chk(vfo_sync_enable_o, 0);
      wt(1'b1, 40); chk(vfo_sync_enable_o, 1);
      chk(mark_strobe_n_o, 0);
      osc(10); pulse(); osc(3);
      chk(vfo_sync_enable_o, 0);
      wt(1'b1, 60); chk(vfo_sync_enable_o, 1);
      osc(150); pulse(); osc(3);
      chk(vfo_sync_enable_o, 1);
      wt(1'b0, 80); chk(vfo_sync_enable_o, 0);
      wt(1'b1, 60); chk(vfo_sync_enable_o, 1);
      read_gate_i <= 1'b0;
      osc(2); chk(vfo_sync_enable_o, 0);
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_regs();
      t_nrz();
      t_wr();
      t_rll();
      print_verdict();
   end
endmodule
bind rll27_endec_sync rll27_endec_sync_sva u_sva (.*);
